/* File: hdl/cfg_pkg.sv */
// Constants, types and field layouts for the configuration command handler.
// Assumes frames arrive already checked by a CAN controller on the same clock.
//
// How it works
// - Use proprietary-A group; destination is our address.
// - Only first byte 0x81 counts as configuration.
// - Second byte selects the parameter number.
// - Third byte: 0 read, 1 write, 2 response.
// - Read data bytes may be absent or ones.
// - Read answer goes back to requester address.
// - Writes apply silently, no answer frame.
// - Parameter 2: period 10 to 2000, default 50.
// - Parameter 3: filter count 1 to 15, default 8.
// - Parameter 4: broadcast group, any value, default ff75.
// - Parameter 5: bit rate code 0 to 3, default 1.
// - Parameter 6: address 0 to 253 usable only.
// - Parameter 7: read-only five byte hardware revision.
// - Power-on address from resistor, else flash, else 80.
// - Later resistor changes never touch the address.
// - Network address write applies now and stores flash.
// - Out-of-range address write is dropped entirely.
package cfg_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] prio;
    logic [1:0] dp;
    logic [7:0] pf;
    logic [7:0] ps;
    logic [7:0] sa;
  } can_id_t;

  typedef struct packed {
    can_id_t         id;
    logic [3:0]      dlc;
    logic [7:0][7:0] data;   // data[0] is the first byte on the wire
  } can_frame_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } tx_state_t;

  // ---------------------------------------------------------------
  // Message codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PF_PROP_A   = 8'hef;
  localparam logic [7:0] CMD_CFG     = 8'h81;
  localparam logic [7:0] OP_READ     = 8'h00;
  localparam logic [7:0] OP_WRITE    = 8'h01;
  localparam logic [7:0] OP_RESP     = 8'h02;
  localparam logic [7:0] PAR_RATE    = 8'h02;
  localparam logic [7:0] PAR_FILT    = 8'h03;
  localparam logic [7:0] PAR_PGN     = 8'h04;
  localparam logic [7:0] PAR_BITRATE = 8'h05;
  localparam logic [7:0] PAR_ADDR    = 8'h06;
  localparam logic [7:0] PAR_HWREV   = 8'h07;
  localparam logic [2:0] RESP_PRIO   = 3'h6;
  localparam logic [1:0] RESP_DP     = 2'h0;
  localparam logic [3:0] RESP_DLC    = 4'h8;
  localparam logic [7:0] RESP_PAD    = 8'h00;
  localparam logic [3:0] DLC_HDR     = 4'h3;
  localparam logic [3:0] DLC_VAL1    = 4'h4;
  localparam logic [3:0] DLC_VAL2    = 4'h5;

  // ---------------------------------------------------------------
  // Parameter limits and defaults
  // ---------------------------------------------------------------
  localparam logic [15:0] RATE_MIN    = 16'h000a;
  localparam logic [15:0] RATE_MAX    = 16'h07d0;
  localparam logic [15:0] RATE_DEF    = 16'h0032;
  localparam logic [7:0]  FILT_MIN    = 8'h01;
  localparam logic [7:0]  FILT_MAX    = 8'h0f;
  localparam logic [3:0]  FILT_DEF    = 4'h8;
  localparam logic [15:0] PGN_DEF     = 16'hff75;
  localparam logic [7:0]  BITRATE_MAX = 8'h03;
  localparam logic [1:0]  BITRATE_DEF = 2'h1;
  localparam logic [7:0]  ADDR_MAX    = 8'hfd;
  localparam logic [7:0]  ADDR_DEF    = 8'h80;
  localparam logic [1:0]  SYNC_FILL   = 2'h2;

  // ---------------------------------------------------------------
  // Register port map
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_SET1   = 5'h08;
  localparam logic [4:0] REG_SET2   = 5'h0c;
  localparam logic       CTRL_RST   = 1'b1;

endpackage

/* File: hdl/addr_select.sv */
// Power-on source address selection from resistor strap, flash or default.
// Assumes resistor inputs come from an ADC outside this clock domain.
`timescale 1ns/1ns
module addr_select (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Resistor strap and stored address
  input  wire logic [7:0] i_res_addr,
  input  wire logic       i_res_open,
  input  wire logic       i_flash_valid,
  input  wire logic [7:0] i_flash_addr,
  // Chosen address
  output logic      [7:0] o_addr,
  output logic            o_done
);
  import cfg_pkg::*;

  logic [8:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic [1:0] wait_q, wait_d;
  logic [7:0] addr_q, addr_d;
  logic       done_q, done_d;

  // Next values: strap caught once after the synchronisers have filled
  always_comb begin
    sync1_d = {i_res_open, i_res_addr};
    sync2_d = sync1_q;
    wait_d  = wait_q;
    addr_d  = addr_q;
    done_d  = done_q;
    if (!done_q) begin
      if (wait_q != SYNC_FILL) begin
        wait_d = wait_q + 2'h1;
      end else begin
        done_d = 1'b1;
        if (!sync2_q[8] && sync2_q[7:0] <= ADDR_MAX) begin
          addr_d = sync2_q[7:0];
        end else if (i_flash_valid && i_flash_addr <= ADDR_MAX) begin
          addr_d = i_flash_addr;
        end else begin
          addr_d = ADDR_DEF;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      wait_q  <= 2'h0;
      addr_q  <= ADDR_DEF;
      done_q  <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      wait_q  <= wait_d;
      addr_q  <= addr_d;
      done_q  <= done_d;
    end
  end

  assign o_addr = addr_q;
  assign o_done = done_q;

endmodule

/* File: hdl/can_config_param_handler.sv */
// Configuration command handler: decodes proprietary-A config frames,
// keeps the node settings and answers reads.
// Assumes a CAN controller on the same clock delivers whole frames as one
// cycle pulses and accepts frames for sending with a ready level.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module can_config_param_handler (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Received frames
  input  wire logic               i_rx_valid,
  input  wire cfg_pkg::can_frame_t i_rx_frame,
  // Frames to send
  output logic                    o_tx_valid,
  output cfg_pkg::can_frame_t     o_tx_frame,
  input  wire logic               i_tx_ready,
  // Address strap and flash
  input  wire logic        [7:0]  i_res_addr,
  input  wire logic               i_res_open,
  input  wire logic               i_flash_valid,
  input  wire logic        [7:0]  i_flash_addr,
  output logic                    o_flash_we,
  output logic             [7:0]  o_flash_data,
  // Fixed hardware revision, low byte first on the wire
  input  wire logic        [39:0] i_hw_rev,
  // Active settings
  output logic             [7:0]  o_src_addr,
  output logic                    o_addr_ready,
  output logic             [15:0] o_msg_rate,
  output logic             [3:0]  o_filt_count,
  output logic             [15:0] o_bcast_pgn,
  output logic             [1:0]  o_bitrate,
  // Register port
  input  wire logic        [4:0]  i_reg_addr,
  input  wire logic        [31:0] i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic             [31:0] o_reg_rdata
);
  import cfg_pkg::*;

  // ---------------------------------------------------------------
  // Power-on address
  // ---------------------------------------------------------------
  logic [7:0] boot_addr;
  logic       boot_done;

  addr_select u_addr_select (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_res_addr    (i_res_addr),
    .i_res_open    (i_res_open),
    .i_flash_valid (i_flash_valid),
    .i_flash_addr  (i_flash_addr),
    .o_addr        (boot_addr),
    .o_done        (boot_done)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tx_state_t   state_q, state_d;
  can_frame_t  tx_frame_q, tx_frame_d;
  logic        tx_valid_q, tx_valid_d;
  logic [7:0]  src_addr_q, src_addr_d;
  logic        ready_q, ready_d;
  logic [15:0] rate_q, rate_d;
  logic [3:0]  filt_q, filt_d;
  logic [15:0] pgn_q, pgn_d;
  logic [1:0]  bitrate_q, bitrate_d;
  logic        flash_we_q, flash_we_d;
  logic [7:0]  flash_data_q, flash_data_d;
  logic        ctrl_en_q, ctrl_en_d;
  logic [31:0] rdata_q, rdata_d;

  // Decoded request fields
  logic        hit;
  logic [7:0]  par;
  logic [7:0]  op;
  logic [7:0]  val8;
  logic [15:0] val16;
  logic        rd_ok;
  logic [39:0] rd_val;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  // proprietary-A to our address
  always_comb begin
    hit = i_rx_valid && ctrl_en_q && ready_q
          && i_rx_frame.id.pf == PF_PROP_A
          && i_rx_frame.id.ps == src_addr_q
          && i_rx_frame.dlc >= DLC_HDR
          && i_rx_frame.data[0] == CMD_CFG;
    par   = i_rx_frame.data[1];
    op    = i_rx_frame.data[2];
    val8  = i_rx_frame.data[3];
    val16 = {i_rx_frame.data[4], i_rx_frame.data[3]};
  end

  // Read value lookup; unknown numbers give no answer
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 40'h0;
    case (par)
      PAR_RATE:    rd_val = {24'h0, rate_q};
      PAR_FILT:    rd_val = {36'h0, filt_q};
      PAR_PGN:     rd_val = {24'h0, pgn_q};
      PAR_BITRATE: rd_val = {38'h0, bitrate_q};
      PAR_ADDR:    rd_val = {32'h0, src_addr_q};
      PAR_HWREV:   rd_val = i_hw_rev;
      default:     rd_ok  = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Command execution and response
  // ---------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    tx_frame_d   = tx_frame_q;
    tx_valid_d   = tx_valid_q;
    src_addr_d   = src_addr_q;
    ready_d      = ready_q;
    rate_d       = rate_q;
    filt_d       = filt_q;
    pgn_d        = pgn_q;
    bitrate_d    = bitrate_q;
    flash_we_d   = 1'b0;
    flash_data_d = flash_data_q;

    if (boot_done && !ready_q) begin
      src_addr_d = boot_addr;
      ready_d    = 1'b1;
    end

    case (state_q)
      ST_IDLE: begin
        if (hit && op == OP_READ && rd_ok) begin
          tx_frame_d.id.prio = RESP_PRIO;
          tx_frame_d.id.dp   = RESP_DP;
          tx_frame_d.id.pf   = PF_PROP_A;
          tx_frame_d.id.ps   = i_rx_frame.id.sa;
          tx_frame_d.id.sa   = src_addr_q;
          tx_frame_d.dlc     = RESP_DLC;
          tx_frame_d.data[0] = CMD_CFG;
          tx_frame_d.data[1] = par;
          tx_frame_d.data[2] = OP_RESP;
          tx_frame_d.data[3] = rd_val[7:0];
          tx_frame_d.data[4] = rd_val[15:8];
          tx_frame_d.data[5] = rd_val[23:16];
          tx_frame_d.data[6] = rd_val[31:24];
          tx_frame_d.data[7] = rd_val[39:32];
          tx_valid_d         = 1'b1;
          state_d            = ST_SEND;
        end
      end
      ST_SEND: begin
        // Hold the frame until the controller takes it
        if (i_tx_ready) begin
          tx_valid_d = 1'b0;
          state_d    = ST_IDLE;
        end
      end
      default: begin
        tx_valid_d = 1'b0;
        state_d    = ST_IDLE;
      end
    endcase

    if (hit && op == OP_WRITE) begin
      case (par)
        PAR_RATE: begin
          if (i_rx_frame.dlc >= DLC_VAL2 && val16 >= RATE_MIN && val16 <= RATE_MAX) begin
            rate_d = val16;
          end
        end
        PAR_FILT: begin
          if (i_rx_frame.dlc >= DLC_VAL1 && val8 >= FILT_MIN && val8 <= FILT_MAX) begin
            filt_d = val8[3:0];
          end
        end
        PAR_PGN: begin
          if (i_rx_frame.dlc >= DLC_VAL2) begin
            pgn_d = val16;
          end
        end
        PAR_BITRATE: begin
          if (i_rx_frame.dlc >= DLC_VAL1 && val8 <= BITRATE_MAX) begin
            bitrate_d = val8[1:0];
          end
        end
        PAR_ADDR: begin
          if (i_rx_frame.dlc >= DLC_VAL1 && val8 <= ADDR_MAX) begin
            src_addr_d   = val8;
            flash_we_d   = 1'b1;
            flash_data_d = val8;
          end
        end
        default: begin
          // Reserved and read-only numbers fall through untouched
          rate_d = rate_q;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Reads answer one cycle later; unmapped addresses read zero
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    rdata_d   = 32'h0;
    if (i_reg_wr) begin
      if (i_reg_addr == REG_CTRL) begin
        ctrl_en_d = i_reg_wdata[0];
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr == REG_CTRL) begin
        rdata_d = {31'h0, ctrl_en_q};
      end else if (i_reg_addr == REG_STATUS) begin
        rdata_d = {22'h0, tx_valid_q, ready_q, src_addr_q};
      end else if (i_reg_addr == REG_SET1) begin
        rdata_d = {pgn_q, rate_q};
      end else if (i_reg_addr == REG_SET2) begin
        rdata_d = {26'h0, bitrate_q, filt_q};
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q      <= ST_IDLE;
      tx_frame_q   <= '0;
      tx_valid_q   <= 1'b0;
      src_addr_q   <= ADDR_DEF;
      ready_q      <= 1'b0;
      rate_q       <= RATE_DEF;
      filt_q       <= FILT_DEF;
      pgn_q        <= PGN_DEF;
      bitrate_q    <= BITRATE_DEF;
      flash_we_q   <= 1'b0;
      flash_data_q <= 8'h00;
      ctrl_en_q    <= CTRL_RST;
      rdata_q      <= 32'h0;
    end else begin
      state_q      <= state_d;
      tx_frame_q   <= tx_frame_d;
      tx_valid_q   <= tx_valid_d;
      src_addr_q   <= src_addr_d;
      ready_q      <= ready_d;
      rate_q       <= rate_d;
      filt_q       <= filt_d;
      pgn_q        <= pgn_d;
      bitrate_q    <= bitrate_d;
      flash_we_q   <= flash_we_d;
      flash_data_q <= flash_data_d;
      ctrl_en_q    <= ctrl_en_d;
      rdata_q      <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign o_tx_valid   = tx_valid_q;
  assign o_tx_frame   = tx_frame_q;
  assign o_flash_we   = flash_we_q;
  assign o_flash_data = flash_data_q;
  assign o_src_addr   = src_addr_q;
  assign o_addr_ready = ready_q;
  assign o_msg_rate   = rate_q;
  assign o_filt_count = filt_q;
  assign o_bcast_pgn  = pgn_q;
  assign o_bitrate    = bitrate_q;
  assign o_reg_rdata  = rdata_q;

endmodule

/* File: tb/cfg_handler_chk_props.sv */
// Port checker for the configuration command handler.
// Assumes it is bound onto the handler top by the bench.
`timescale 1ns/1ns
module cfg_handler_chk (
  // Clock and reset
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  // Frame link
  input wire logic                i_rx_valid,
  input wire cfg_pkg::can_frame_t i_rx_frame,
  input wire logic                o_tx_valid,
  input wire cfg_pkg::can_frame_t o_tx_frame,
  input wire logic                i_tx_ready,
  // Address and settings
  input wire logic [7:0]          i_res_addr,
  input wire logic                i_res_open,
  input wire logic                i_flash_valid,
  input wire logic [7:0]          i_flash_addr,
  input wire logic                o_flash_we,
  input wire logic [7:0]          o_flash_data,
  input wire logic [7:0]          o_src_addr,
  input wire logic                o_addr_ready,
  input wire logic [15:0]         o_msg_rate,
  input wire logic [3:0]          o_filt_count,
  // Register port
  input wire logic [4:0]          i_reg_addr,
  input wire logic [31:0]         i_reg_wdata,
  input wire logic                i_reg_wr
);
  import cfg_pkg::*;
  // ----------------
  // Frame decode
  // ----------------
  logic en_q;
  logic en_d;
  // Mirror of the enable bit, since frames are ignored while it is clear
  always_comb begin
    en_d = en_q;
    if (i_reg_wr && i_reg_addr == REG_CTRL) en_d = i_reg_wdata[0];
  end
  always_ff @(posedge i_clk) begin
    en_q <= i_rst_n ? en_d : 1'b1;
  end
  wire logic [7:0]  par = i_rx_frame.data[1];
  wire logic [7:0]  op  = i_rx_frame.data[2];
  wire logic [7:0]  v0  = i_rx_frame.data[3];
  wire logic [15:0] v16 = {i_rx_frame.data[4], i_rx_frame.data[3]};
  wire logic cfg = i_rx_valid && en_q && o_addr_ready && i_rx_frame.id.pf == PF_PROP_A
                   && i_rx_frame.id.ps == o_src_addr && i_rx_frame.dlc >= DLC_HDR
                   && i_rx_frame.data[0] == CMD_CFG;
  wire logic [7:0] boot_sa = (!i_res_open && i_res_addr <= ADDR_MAX) ? i_res_addr :
                             (i_flash_valid && i_flash_addr <= ADDR_MAX) ? i_flash_addr : ADDR_DEF;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_read;
    cfg && op == OP_READ && par >= PAR_RATE && par <= PAR_HWREV && !o_tx_valid;
  endsequence
  sequence s_wr(logic [7:0] p);
    cfg && op == OP_WRITE && par == p;
  endsequence
  // ----------------
  // Properties
  // ----------------
  a_read_answer:
  assert property (s_read |=> o_tx_valid && o_tx_frame.id.ps == $past(i_rx_frame.id.sa)
    && o_tx_frame.data[2] == OP_RESP && o_tx_frame.data[1] == $past(par)) else $error("read unanswered");
  a_tx_hold:
  assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame)) else $error("tx moved");
  a_tx_drop:
  assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid) else $error("tx not dropped");
  a_write_silent:
  assert property (cfg && op != OP_READ && !o_tx_valid |=> !o_tx_valid) else $error("write answered");
  a_rate_set:
  assert property (s_wr(PAR_RATE) && i_rx_frame.dlc >= DLC_VAL2 && v16 >= RATE_MIN && v16 <= RATE_MAX
    |=> o_msg_rate == $past(v16)) else $error("rate not set");
  a_filt_keep:
  assert property (s_wr(PAR_FILT) && (v0 < FILT_MIN || v0 > FILT_MAX) |=> $stable(o_filt_count))
    else $error("filter changed");
  a_addr_take:
  assert property (s_wr(PAR_ADDR) && i_rx_frame.dlc >= DLC_VAL1 && v0 <= ADDR_MAX
    |=> o_src_addr == $past(v0) && o_flash_we && o_flash_data == $past(v0)) else $error("addr not taken");
  a_addr_drop:
  assert property (s_wr(PAR_ADDR) && v0 > ADDR_MAX |=> $stable(o_src_addr) && !o_flash_we)
    else $error("bad addr used");
  a_addr_fixed:
  assert property (o_addr_ready && $past(o_addr_ready) && $changed(o_src_addr) |-> o_flash_we)
    else $error("addr moved");
  a_boot_addr:
  assert property ($rose(o_addr_ready) |-> o_src_addr == boot_sa) else $error("boot addr wrong");
  a_boot_time:
  assert property ($rose(i_rst_n) |-> ##[2:6] o_addr_ready) else $error("boot too slow");
endmodule

/* File: tb/cfg_tool_model.sv */
// Far-side CAN controller that takes response frames from the handler.
// Assumes the bench picks prompt or slow acceptance.
`timescale 1ns/1ns
module cfg_tool_model (
  // Clock and mode
  input  wire logic i_clk,
  input  wire logic i_slow,
  // Send handshake
  input  wire logic i_valid,
  output logic      o_ready
);
  logic [1:0] wait_q = 2'h0;
  logic [1:0] wait_d;
  // take responses
  // Slow mode stalls three cycles so the held frame is exercised
  always_comb begin
    wait_d = (i_valid && !o_ready) ? wait_q + 2'h1 : 2'h0;
  end
  always_ff @(posedge i_clk) begin
    wait_q <= wait_d;
  end
  assign o_ready = i_valid && (!i_slow || wait_q == 2'h3);
endmodule

/* File: tb/can_config_param_handler_test.sv */
// Self-checking bench for the configuration command handler.
// Assumes the checker and tool model are compiled before it.
`timescale 1ns/1ns
module can_config_param_handler_test;
  import cfg_pkg::*;
  logic       i_clk = 1'b0, i_rst_n = 1'b0, i_rx_valid = 1'b0, i_res_open = 1'b0, i_flash_valid = 1'b1;
  logic       i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0, rd_d = 1'b0;
  logic       o_tx_valid, i_tx_ready, o_flash_we, o_addr_ready;
  can_frame_t i_rx_frame = '0, o_tx_frame;
  logic [7:0] i_res_addr = 8'h30, i_flash_addr = 8'h55, o_flash_data, o_src_addr, m_sa, alt = 8'h0;
  logic [39:0] i_hw_rev = 40'h01_0004_0114;  // Arbitrary revision value
  logic [15:0] o_msg_rate, o_bcast_pgn, m_rate, m_pgn;
  logic [3:0] o_filt_count, m_filt;
  logic [1:0] o_bitrate, m_br;
  logic [4:0] i_reg_addr = 5'h0;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, seed = 32'h11, r;
  logic [127:0] txq[$];
  logic [31:0] rdq[$];
  int n_mismatch = 0, check_count = 0, cyc = 0;
  logic [7:0] wp [18] = '{8'h2, 8'h2, 8'h2, 8'h2, 8'h2, 8'h3, 8'h3, 8'h3, 8'h4, 8'h5, 8'h5, 8'h5, 8'h5,
                          8'h5, 8'h6, 8'h6, 8'h7, 8'h1};
  logic [15:0] wv [18] = '{16'ha, 16'h7d1, 16'h7d0, 16'h64, 16'h9, 16'h0, 16'hf, 16'h10, 16'h1234, 16'h0,
                           16'h1, 16'h2, 16'h3, 16'h4, 16'hfe, 16'h22, 16'h5, 16'h5};

  always #4 i_clk = ~i_clk;

  can_config_param_handler dut (.i_clk, .i_rst_n, .i_rx_valid, .i_rx_frame, .o_tx_valid, .o_tx_frame,
    .i_tx_ready, .i_res_addr, .i_res_open, .i_flash_valid, .i_flash_addr, .o_flash_we, .o_flash_data,
    .i_hw_rev, .o_src_addr, .o_addr_ready, .o_msg_rate, .o_filt_count, .o_bcast_pgn, .o_bitrate,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  cfg_tool_model tool (.i_clk, .i_slow(slow), .i_valid(o_tx_valid), .o_ready(i_tx_ready));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [127:0] exp_resp(input logic [7:0] p);
    logic [39:0] v;
    can_frame_t f;
    case (p)
      PAR_RATE:    v = {24'h0, m_rate};
      PAR_FILT:    v = {36'h0, m_filt};
      PAR_PGN:     v = {24'h0, m_pgn};
      PAR_BITRATE: v = {38'h0, m_br};
      PAR_ADDR:    v = {32'h0, m_sa};
      default:     v = i_hw_rev;
    endcase
    f = '{id: '{RESP_PRIO, RESP_DP, PF_PROP_A, 8'hf9, m_sa}, dlc: RESP_DLC, data: {v, OP_RESP, p, CMD_CFG}};
    return 128'(f);
  endfunction

  task automatic send(input logic [7:0] d0, p, op, input logic [39:0] v, input logic [3:0] dlc);
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    i_rx_frame <= '{id: '{3'h6, 2'h0, PF_PROP_A, m_sa ^ alt, 8'hf9}, dlc: dlc, data: {v, op, p, d0}};
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
  endtask

  task automatic reg_op(input logic w, input logic [4:0] a, input logic [31:0] d);
    if (!w) rdq.push_back(d);
    @(posedge i_clk);
    i_reg_wr <= w;
    i_reg_rd <= !w;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
  endtask

  task automatic cmp_all();
    check(128'(o_msg_rate), 128'(m_rate));
    check(128'(o_filt_count), 128'(m_filt));
    check(128'(o_bcast_pgn), 128'(m_pgn));
    check(128'(o_bitrate), 128'(m_br));
    check(128'(o_src_addr), 128'(m_sa));
  endtask

  // Waits out a pending response so a new read is not dropped
  task automatic drain();
    for (int i = 0; i < 40 && txq.size() > 0; i++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask

  task automatic done(input string s);
    drain();
    check(128'(txq.size()), 128'h0);
    txq.delete();
    $display("test %s done", s);
  endtask

  task automatic rd_par(input logic [7:0] p, input logic full);
    drain();
    if (p >= PAR_RATE && p <= PAR_HWREV) txq.push_back(exp_resp(p));
    send(CMD_CFG, p, OP_READ, {40{full}}, full ? 4'h8 : DLC_HDR);
  endtask

  task automatic wr_par(input logic [7:0] p, input logic [15:0] v, input logic [3:0] dlc);
    logic ok;
    logic fl;
    ok = dlc >= ((p == PAR_RATE || p == PAR_PGN) ? DLC_VAL2 : DLC_VAL1);
    fl = 1'b0;
    send(CMD_CFG, p, OP_WRITE, {24'hffffff, v}, dlc);
    case (p)
      PAR_RATE:    if (ok && v >= RATE_MIN && v <= RATE_MAX) m_rate = v;
      PAR_FILT:    if (ok && v[7:0] >= FILT_MIN && v[7:0] <= FILT_MAX) m_filt = v[3:0];
      PAR_PGN:     if (ok) m_pgn = v;
      PAR_BITRATE: if (ok && v[7:0] <= BITRATE_MAX) m_br = v[1:0];
      PAR_ADDR:    fl = ok && v[7:0] <= ADDR_MAX;
      default:     ;
    endcase
    if (fl) m_sa = v[7:0];
    @(negedge i_clk);
    check(128'(o_flash_we), 128'(fl));
    if (fl) check(128'(o_flash_data), 128'(m_sa));
    cmp_all();
  endtask

  task automatic boot(input logic open, input logic fv, input logic [7:0] exp_sa);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_res_open <= open;
    i_flash_valid <= fv;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    {m_rate, m_filt, m_pgn, m_br, m_sa} = {RATE_DEF, FILT_DEF, PGN_DEF, BITRATE_DEF, exp_sa};
    for (int i = 0; i < 10 && o_addr_ready !== 1'b1; i++) @(negedge i_clk);
    check(128'(o_addr_ready), 128'h1);
    cmp_all();
    done("boot");
  endtask

  // Oldest note is compared whenever a result shows at the ports
  always @(posedge i_clk) begin
    rd_d <= i_reg_rd;
    cyc <= cyc + 1;
    if (rd_d) check(128'(o_reg_rdata), 128'(rdq.pop_front()));
    if (o_tx_valid && i_tx_ready && txq.size() == 0) check(128'h1, 128'h0);
    else if (o_tx_valid && i_tx_ready) check(128'(o_tx_frame), txq.pop_front());
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    boot(1'b0, 1'b1, 8'h30);
    @(posedge i_clk);
    i_res_addr <= 8'h44;
    repeat (8) @(negedge i_clk);
    check(128'(o_src_addr), 128'(m_sa));
    for (int p = 1; p < 9; p++) begin
      slow <= p[1];
      rd_par(8'(p), p[0]);
    end
    done("read");
    for (int i = 0; i < 18; i++) wr_par(wp[i], wv[i], i == 3 ? DLC_VAL1 : 4'h8);
    done("write");
    repeat (12) begin
      r = xs();
      wr_par(8'(r[2:0]) + 8'h2, r[3] ? r[31:16] : {11'h0, r[8:4]}, 4'h8);
    end
    for (int p = 2; p < 8; p++) rd_par(8'(p), 1'b1);
    done("random");
    send(8'h12, PAR_RATE, OP_READ, '1, 4'h8);
    send(CMD_CFG, PAR_RATE, OP_RESP, 40'h64, 4'h8);
    alt = 8'h1;
    send(CMD_CFG, PAR_RATE, OP_READ, '1, 4'h8);
    alt = 8'h0;
    @(negedge i_clk);
    cmp_all();
    // Slow acceptance keeps this answer pending, so the next read must be dropped
    slow <= 1'b1;
    rd_par(PAR_FILT, 1'b1);
    send(CMD_CFG, PAR_RATE, OP_READ, '1, 4'h8);
    done("ignore");
    reg_op(1'b0, REG_CTRL, 32'h1);
    reg_op(1'b0, REG_SET1, {m_pgn, m_rate});
    reg_op(1'b0, REG_SET2, {26'h0, m_br, m_filt});
    reg_op(1'b0, REG_STATUS, {22'h0, 2'h1, m_sa});
    reg_op(1'b1, 5'h14, 32'h0);
    reg_op(1'b0, 5'h10, 32'h0);
    reg_op(1'b1, REG_CTRL, 32'h0);
    send(CMD_CFG, PAR_RATE, OP_READ, '1, 4'h8);
    reg_op(1'b0, REG_CTRL, 32'h0);
    reg_op(1'b1, REG_CTRL, 32'h1);
    done("regs");
    boot(1'b1, 1'b1, 8'h55);
    boot(1'b1, 1'b0, 8'h80);
    results();
  end
endmodule

bind can_config_param_handler cfg_handler_chk chk (.i_clk, .i_rst_n, .i_rx_valid, .i_rx_frame, .o_tx_valid,
  .o_tx_frame, .i_tx_ready, .i_res_addr, .i_res_open, .i_flash_valid, .i_flash_addr, .o_flash_we,
  .o_flash_data, .o_src_addr, .o_addr_ready, .o_msg_rate, .o_filt_count, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr);
